// >>> port_jkl_pkg.sv
// constants shared by the port j/k/l alternate-function override block
// assumes a 32-bit classic wishbone slave port with byte addresses
`default_nettype none

package port_jkl_pkg;

    // pin vector layout: port j, then port k, then port l
    localparam int PORT_W   = 8;
    localparam int NUM_PINS = 24;
    localparam int J_BASE   = 0;
    localparam int K_BASE   = 8;
    localparam int L_BASE   = 16;
    localparam int GRP1_W   = 7;

    // port j bit roles
    localparam int J_RX_BIT  = 0;
    localparam int J_TX_BIT  = 1;
    localparam int J_XCK_BIT = 2;
    localparam int J_FREE    = 7;

    // port l bit roles
    localparam int L_CAP4_BIT = 0;
    localparam int L_CAP5_BIT = 1;
    localparam int L_T5CK_BIT = 2;
    localparam int L_CMPA_BIT = 3;
    localparam int CMP_W      = 3;

    // register byte offsets
    localparam int            ADR_W       = 8;
    localparam logic [7:0]    CTRL_OFS    = 8'h00;
    localparam logic [7:0]    MASK1_OFS   = 8'h04;
    localparam logic [7:0]    MASK2_OFS   = 8'h08;
    localparam logic [7:0]    JLAT_OFS    = 8'h0C;
    localparam logic [7:0]    JDIR_OFS    = 8'h10;
    localparam logic [7:0]    KLAT_OFS    = 8'h14;
    localparam logic [7:0]    KDIR_OFS    = 8'h18;
    localparam logic [7:0]    LLAT_OFS    = 8'h1C;
    localparam logic [7:0]    LDIR_OFS    = 8'h20;
    localparam logic [7:0]    KDIS_OFS    = 8'h24;
    localparam logic [7:0]    PINS_OFS    = 8'h28;
    localparam logic [7:0]    STAT_OFS    = 8'h2C;
    localparam logic [7:0]    IMSK_OFS    = 8'h30;

    // control register fields
    localparam int CTRL_PUD_BIT  = 0;
    localparam int CTRL_GRP1_BIT = 1;
    localparam int CTRL_GRP2_BIT = 2;
    localparam int CTRL_TXEN_BIT = 3;
    localparam int CTRL_RXEN_BIT = 4;
    localparam int CTRL_SYNC_BIT = 5;
    localparam int CTRL_W        = 6;

    // status and interrupt mask fields
    localparam int STAT_GRP1_BIT = 0;
    localparam int STAT_GRP2_BIT = 1;
    localparam int STAT_W        = 2;

    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic [31:0] WORD_0   = 32'h0000_0000;

endpackage : port_jkl_pkg

`default_nettype wire

// >>> pin_sync.sv
// two-flop synchroniser for the raw pad inputs
// assumes the pads are asynchronous to clock; only the second stage reads the first stage
`default_nettype none

module pin_sync
    import port_jkl_pkg::*;
#(
    parameter int W = NUM_PINS
) (
    input  wire logic         clock,    // system clock
    input  wire logic         sys_rst,  // async reset, high
    input  wire logic         ce,       // clock enable
    input  wire logic [W-1:0] rawIn,    // raw pad levels
    output logic      [W-1:0] syncOut   // synchronised levels
);

    logic [W-1:0] stage1_r;

    // first stage only feeds the second stage
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_r <= '0;
            syncOut  <= '0;
        end else if (ce) begin
            stage1_r <= rawIn;
            syncOut  <= stage1_r;
        end
    end

endmodule : pin_sync

`default_nettype wire

// >>> pin_override_cell.sv
// one pin's override multiplexer: each pair swaps a register setting
// assumes the caller registers the results; purely combinational
`default_nettype none

module pin_override_cell (
    input  wire logic normPullup,  // pull-up from latch and direction
    input  wire logic normDir,     // direction register bit
    input  wire logic normOut,     // output latch bit
    input  wire logic normInEn,    // normal input enable
    input  wire logic pullup_override_enable,        // pullup_override_enable
    input  wire logic pullup_override_value,        // pullup_override_value
    input  wire logic direction_override_enable,        // direction_override_enable
    input  wire logic direction_override_value,        // direction_override_value
    input  wire logic output_value_override_enable,        // output_value_override_enable
    input  wire logic output_value_override_value,        // output_value_override_value
    input  wire logic ieOe,        // input_enable_override_enable
    input  wire logic ieOv,        // input_enable_override_value
    input  wire logic pullupOff,   // global_pullup_disable
    output logic      pullEn,      // final pull-up
    output logic      dir,         // final direction, 1 = output
    output logic      outVal,      // final driven value
    output logic      inEn         // final input enable
);

    // substitute the override value while its enable is set
    assign pullEn = (pullup_override_enable ? pullup_override_value : normPullup) & ~pullupOff;
    assign dir    = direction_override_enable ? direction_override_value : normDir;
    assign outVal = output_value_override_enable ? output_value_override_value : normOut;
    assign inEn   = ieOe ? ieOv : normInEn;

endmodule : pin_override_cell

`default_nettype wire

// >>> port_jkl_override.sv
// alternate-function override for ports j, k and l, with wishbone registers
// assumes pads are resolved outside from pinOutVal and pinDriveEn_n
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none

module port_jkl_override
    import port_jkl_pkg::*;
(
    input  wire logic                  clock,                  // system clock
    input  wire logic                  sys_rst,                // async reset, high
    input  wire logic                  ce,                     // clock enable
    input  wire logic                  cyc_i,                  // wishbone cycle
    input  wire logic                  stb_i,                  // wishbone strobe
    input  wire logic                  we_i,                   // wishbone write
    input  wire logic [ADR_W-1:0]      adr_i,                  // byte address
    input  wire logic [3:0]            sel_i,                  // byte selects
    input  wire logic [31:0]           dat_i,                  // write data
    output logic      [31:0]           dat_o,                  // read data
    output logic                       ack_o,                  // wishbone ack
    output logic                       irq,                    // interrupt level
    input  wire logic [NUM_PINS-1:0]   pinIn,                  // raw pad levels
    output logic      [NUM_PINS-1:0]   pinOutVal,              // pad drive value
    output logic      [NUM_PINS-1:0]   pinDriveEn_n,           // low = pad driven
    output logic      [NUM_PINS-1:0]   pinPullup,              // pull-up on
    output logic      [NUM_PINS-1:0]   pinInputEn,             // digital input on
    input  wire logic                  serial3TransmitLine,    // transmit data
    input  wire logic                  serial3ClockOut,        // clock to drive
    output logic                       serial3ReceiveLine,     // receive data
    output logic                       serial3ExternalClock,   // clock from pad
    output logic      [GRP1_W-1:0]     changeSourcesGroupOne,  // sources 15..9
    output logic      [PORT_W-1:0]     changeSourcesGroupTwo,  // sources 23..16
    input  wire logic [CMP_W-1:0]      timer5CompareEn,        // c, b, a enables
    input  wire logic [CMP_W-1:0]      timer5CompareOut,       // c, b, a levels
    output logic                       timer5ExternalClock,    // timer five clock
    output logic                       timer5CaptureTrigger,   // timer five capture
    output logic                       timer4CaptureTrigger    // timer four capture
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [CTRL_W-1:0]   ctrl_r;
    logic [GRP1_W-1:0]   mask1_r;
    logic [PORT_W-1:0]   mask2_r;
    logic [NUM_PINS-1:0] latch_r;
    logic [NUM_PINS-1:0] dir_r;
    logic [PORT_W-1:0]   kDis_r;
    logic [STAT_W-1:0]   stat_r;
    logic [STAT_W-1:0]   stat_nxt;
    logic [STAT_W-1:0]   imsk_r;
    logic [NUM_PINS-1:0] pinSync;
    logic [NUM_PINS-1:0] pinPrev_r;
    logic [31:0]         rdData;
    logic                access;
    logic                wrEn;
    logic                statRead;
    logic                global_pullup_disable;
    logic                grp1;
    logic                grp2;
    logic                txEn;
    logic                rxEn;
    logic                syncMode;
    logic                xckOutEn;
    logic                evGrp1;
    logic                evGrp2;

    assign global_pullup_disable      = ctrl_r[CTRL_PUD_BIT];
    assign grp1     = ctrl_r[CTRL_GRP1_BIT];
    assign grp2     = ctrl_r[CTRL_GRP2_BIT];
    assign txEn     = ctrl_r[CTRL_TXEN_BIT];
    assign rxEn     = ctrl_r[CTRL_RXEN_BIT];
    assign syncMode = ctrl_r[CTRL_SYNC_BIT];

    // one-cycle answer: ack rises the cycle after the request, then drops
    assign access   = cyc_i & stb_i & ~ack_o;
    assign wrEn     = access & we_i & sel_i[0];
    assign statRead = access & ~we_i & (adr_i == STAT_OFS);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_o <= 1'b0;
        end else if (ce) begin
            ack_o <= access;
        end
    end

    // software-written settings; registers are up to 8 bits in byte lane 0
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r  <= REG_RST[CTRL_W-1:0];
            mask1_r <= REG_RST[GRP1_W-1:0];
            mask2_r <= REG_RST;
            latch_r <= '0;
            dir_r   <= '0;
            kDis_r  <= REG_RST;
            imsk_r  <= REG_RST[STAT_W-1:0];
        end else if (ce && wrEn) begin
            case (adr_i)
                CTRL_OFS:  ctrl_r  <= dat_i[CTRL_W-1:0];
                MASK1_OFS: mask1_r <= dat_i[GRP1_W-1:0];
                MASK2_OFS: mask2_r <= dat_i[PORT_W-1:0];
                JLAT_OFS:  latch_r[J_BASE+:PORT_W] <= dat_i[PORT_W-1:0];
                JDIR_OFS:  dir_r[J_BASE+:PORT_W]   <= dat_i[PORT_W-1:0];
                KLAT_OFS:  latch_r[K_BASE+:PORT_W] <= dat_i[PORT_W-1:0];
                KDIR_OFS:  dir_r[K_BASE+:PORT_W]   <= dat_i[PORT_W-1:0];
                LLAT_OFS:  latch_r[L_BASE+:PORT_W] <= dat_i[PORT_W-1:0];
                LDIR_OFS:  dir_r[L_BASE+:PORT_W]   <= dat_i[PORT_W-1:0];
                KDIS_OFS:  kDis_r  <= dat_i[PORT_W-1:0];
                IMSK_OFS:  imsk_r  <= dat_i[STAT_W-1:0];
                default: ;  // unmapped or read-only: write ignored, still acked
            endcase
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rdData = WORD_0;
        case (adr_i)
            CTRL_OFS:  rdData[CTRL_W-1:0] = ctrl_r;
            MASK1_OFS: rdData[GRP1_W-1:0] = mask1_r;
            MASK2_OFS: rdData[PORT_W-1:0] = mask2_r;
            JLAT_OFS:  rdData[PORT_W-1:0] = latch_r[J_BASE+:PORT_W];
            JDIR_OFS:  rdData[PORT_W-1:0] = dir_r[J_BASE+:PORT_W];
            KLAT_OFS:  rdData[PORT_W-1:0] = latch_r[K_BASE+:PORT_W];
            KDIR_OFS:  rdData[PORT_W-1:0] = dir_r[K_BASE+:PORT_W];
            LLAT_OFS:  rdData[PORT_W-1:0] = latch_r[L_BASE+:PORT_W];
            LDIR_OFS:  rdData[PORT_W-1:0] = dir_r[L_BASE+:PORT_W];
            KDIS_OFS:  rdData[PORT_W-1:0] = kDis_r;
            PINS_OFS:  rdData[NUM_PINS-1:0] = pinSync & pinInputEn;
            STAT_OFS:  rdData[STAT_W-1:0] = stat_r;
            IMSK_OFS:  rdData[STAT_W-1:0] = imsk_r;
            default:   rdData = WORD_0;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dat_o <= WORD_0;
        end else if (ce) begin
            dat_o <= access ? rdData : WORD_0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad inputs and change detection

    pin_sync #(.W(NUM_PINS)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ce      (ce),
        .rawIn   (pinIn),
        .syncOut (pinSync)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pinPrev_r <= '0;
        end else if (ce) begin
            pinPrev_r <= pinSync;
        end
    end

    // a masked source that toggles while its group is enabled is an event
    assign evGrp1 = grp1 & |(mask1_r & (pinSync[J_BASE+:GRP1_W]
                             ^ pinPrev_r[J_BASE+:GRP1_W]));
    assign evGrp2 = grp2 & |(mask2_r & (pinSync[K_BASE+:PORT_W]
                             ^ pinPrev_r[K_BASE+:PORT_W]));

    // sticky status; a read clears it but a same-cycle event wins
    always_comb begin
        stat_nxt = statRead ? '0 : stat_r;
        if (evGrp1) begin
            stat_nxt[STAT_GRP1_BIT] = 1'b1;
        end
        if (evGrp2) begin
            stat_nxt[STAT_GRP2_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stat_r <= '0;
            irq    <= 1'b0;
        end else if (ce) begin
            stat_r <= stat_nxt;
            irq    <= |(stat_nxt & imsk_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // override terms for each pin

    logic [NUM_PINS-1:0] pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, output_value_override_enable, output_value_override_value, ieOe, normIe;
    logic [NUM_PINS-1:0] pullC, dirC, outC, ieC;

    // serial clock drives its pin only in synchronous mode with the direction bit set
    assign xckOutEn = syncMode & dir_r[J_BASE+J_XCK_BIT];

    always_comb begin
        pullup_override_enable   = '0;
        pullup_override_value   = '0;
        direction_override_enable   = '0;
        direction_override_value   = '0;
        output_value_override_enable   = '0;
        output_value_override_value   = '0;
        ieOe   = '0;
        normIe = '1;
        // port j: bits 6..0 are change inputs, bit 7 left alone
        ieOe[J_BASE+:GRP1_W] = mask1_r & {GRP1_W{grp1}};
        // transmit takes bit 1 as a driven output without pull-up
        pullup_override_enable[J_BASE+J_TX_BIT] = txEn;
        direction_override_enable[J_BASE+J_TX_BIT] = txEn;
        direction_override_value[J_BASE+J_TX_BIT] = 1'b1;
        output_value_override_enable[J_BASE+J_TX_BIT] = txEn;
        output_value_override_value[J_BASE+J_TX_BIT] = serial3TransmitLine;
        // receiver forces bit 0 to input; latch bit then picks pull-up
        pullup_override_enable[J_BASE+J_RX_BIT] = rxEn;
        pullup_override_value[J_BASE+J_RX_BIT] = latch_r[J_BASE+J_RX_BIT] & ~global_pullup_disable;
        direction_override_enable[J_BASE+J_RX_BIT] = rxEn;
        // serial clock output on bit 2
        direction_override_enable[J_BASE+J_XCK_BIT] = xckOutEn;
        direction_override_value[J_BASE+J_XCK_BIT] = 1'b1;
        output_value_override_enable[J_BASE+J_XCK_BIT] = xckOutEn;
        output_value_override_value[J_BASE+J_XCK_BIT] = serial3ClockOut;
        // port k: normal input enable follows the converter disable bits
        normIe[K_BASE+:PORT_W] = ~kDis_r;
        ieOe[K_BASE+:PORT_W]   = mask2_r & {PORT_W{grp2}};
        // port l: compare outputs a, b, c on bits 3, 4, 5
        output_value_override_enable[L_BASE+L_CMPA_BIT+:CMP_W] = timer5CompareEn;
        output_value_override_value[L_BASE+L_CMPA_BIT+:CMP_W] = timer5CompareOut;
    end

    // the analog path of port k bits goes to converter channels 8..15 at the pad
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_cell
        pin_override_cell u_cell (
            .normPullup (latch_r[i] & ~dir_r[i]),
            .normDir    (dir_r[i]),
            .normOut    (latch_r[i]),
            .normInEn   (normIe[i]),
            .pullup_override_enable       (pullup_override_enable[i]),
            .pullup_override_value       (pullup_override_value[i]),
            .direction_override_enable       (direction_override_enable[i]),
            .direction_override_value       (direction_override_value[i]),
            .output_value_override_enable       (output_value_override_enable[i]),
            .output_value_override_value       (output_value_override_value[i]),
            .ieOe       (ieOe[i]),
            .ieOv       (1'b1),
            .pullupOff  (global_pullup_disable),
            .pullEn     (pullC[i]),
            .dir        (dirC[i]),
            .outVal     (outC[i]),
            .inEn       (ieC[i])
        );
    end

    // pad controls registered so every output leaves a flip-flop
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pinOutVal    <= '0;
            pinDriveEn_n <= '1;
            pinPullup    <= '0;
            pinInputEn   <= '1;
        end else if (ce) begin
            pinOutVal    <= outC;
            pinDriveEn_n <= ~dirC;
            pinPullup    <= pullC;
            pinInputEn   <= ieC;
        end
    end

    // peripheral inputs; receive and change sources gated by the current input enable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial3ReceiveLine    <= 1'b0;
            serial3ExternalClock  <= 1'b0;
            changeSourcesGroupOne <= '0;
            changeSourcesGroupTwo <= '0;
            timer5ExternalClock   <= 1'b0;
            timer5CaptureTrigger  <= 1'b0;
            timer4CaptureTrigger  <= 1'b0;
        end else if (ce) begin
            serial3ReceiveLine    <= pinSync[J_BASE+J_RX_BIT] & ieC[J_BASE+J_RX_BIT];
            serial3ExternalClock  <= pinSync[J_BASE+J_XCK_BIT] & syncMode
                                     & ~dir_r[J_BASE+J_XCK_BIT];
            changeSourcesGroupOne <= pinSync[J_BASE+:GRP1_W] & ieC[J_BASE+:GRP1_W];
            changeSourcesGroupTwo <= pinSync[K_BASE+:PORT_W] & ieC[K_BASE+:PORT_W];
            timer5ExternalClock   <= pinSync[L_BASE+L_T5CK_BIT];
            timer5CaptureTrigger  <= pinSync[L_BASE+L_CAP5_BIT];
            timer4CaptureTrigger  <= pinSync[L_BASE+L_CAP4_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence grp1Edge_s;
        ce && evGrp1;
    endsequence

    sequence statSet1_s;
        // irq is registered from the old mask, so it trails a mask write by one cycle
        stat_r[STAT_GRP1_BIT] ##0 (irq || !$past(imsk_r[STAT_GRP1_BIT]));
    endsequence

    tx_pin_a: assert property (ce && txEn |=> !pinDriveEn_n[J_BASE+J_TX_BIT]
        && !pinPullup[J_BASE+J_TX_BIT]
        && pinOutVal[J_BASE+J_TX_BIT] == $past(serial3TransmitLine))
        else $error("transmit pin not overridden");
    rx_input_a: assert property (ce && rxEn |=> pinDriveEn_n[J_BASE+J_RX_BIT])
        else $error("receive pin not forced to input");
    rx_pullup_a: assert property (ce && rxEn |=> pinPullup[J_BASE+J_RX_BIT]
        == ($past(latch_r[J_BASE+J_RX_BIT]) && !$past(global_pullup_disable)))
        else $error("receive pin pull-up wrong");
    pud_off_a: assert property (ce && global_pullup_disable |=> pinPullup == '0)
        else $error("pull-up on while disabled");
    j_inen_a: assert property (ce && grp1 && mask1_r[6] |=> pinInputEn[J_BASE+6])
        else $error("port j input enable not forced");
    k_inen_a: assert property (ce && grp2 && mask2_r[0] && kDis_r[0]
        |=> pinInputEn[K_BASE])
        else $error("port k input enable not forced");
    xck_out_a: assert property (ce && syncMode && dir_r[J_BASE+J_XCK_BIT]
        |=> !pinDriveEn_n[J_BASE+J_XCK_BIT]
        && pinOutVal[J_BASE+J_XCK_BIT] == $past(serial3ClockOut))
        else $error("serial clock not driven");
    xck_async_a: assert property (ce && !syncMode |=> !serial3ExternalClock
        && pinDriveEn_n[J_BASE+J_XCK_BIT] == !$past(dir_r[J_BASE+J_XCK_BIT]))
        else $error("serial clock active outside synchronous mode");
    cmp_out_a: assert property (ce && timer5CompareEn[0]
        |=> pinOutVal[L_BASE+L_CMPA_BIT] == $past(timer5CompareOut[0]))
        else $error("compare output a not routed");
    cap_route_a: assert property (ce |=> timer5CaptureTrigger
        == $past(pinSync[L_BASE+L_CAP5_BIT]))
        else $error("capture input not routed");
    grp1_event_a: assert property (grp1Edge_s |=> statSet1_s)
        else $error("group one change not latched");
    grp2_event_a: assert property (ce && evGrp2 |=> stat_r[STAT_GRP2_BIT])
        else $error("group two change not latched");

endmodule : port_jkl_override

`default_nettype wire

// >>> pad_side_model.sv
// stand-in for the board pads and the on-chip peripherals around the block
// assumes one clock; everything changes just after a rising edge
`default_nettype none
module pad_side_model (
    input  wire logic        clock,   // system clock
    input  wire logic [23:0] padSet,  // pad levels the bench asks for
    output logic      [23:0] pinIn,   // pad levels seen by the block
    output logic             txLine,  // transmit data, toggles every cycle
    output logic             clkOut,  // serial clock out, opposite phase
    output logic      [2:0]  cmpEn,   // compare enables c, b, a
    output logic      [2:0]  cmpOut   // compare levels c, b, a
);
    timeunit 1ns;
    timeprecision 1ps;
    // pads lag the bench by one edge; a toggling tx exposes a stale copy
    always @(posedge clock) begin
        pinIn  <= padSet;
        txLine <= (txLine === 1'b1) ? 1'b0 : 1'b1;
    end
    // compare levels share the toggling pattern
    assign clkOut = ~txLine;
    assign cmpEn  = 3'b111;
    assign cmpOut = {3{txLine}};
endmodule : pad_side_model
`default_nettype wire

// >>> port_jkl_override_bench.sv
// self-checking bench for the port j/k/l override block
// assumes pad_side_model on the pad side and a wishbone master here
`default_nettype none
module port_jkl_override_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import port_jkl_pkg::*;
    logic clock = 1'b0, sysRst, cyc, stb, we, ack, irq, tx, ck, t5ck;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, rq;
    logic [23:0] padSet, pinIn, outV, drvN, pull, inEn;
    logic [2:0]  cmpEn, cmpOut;
    logic        rx, xck, t5cap, t4cap;
    logic [6:0]  chg1;
    logic [7:0]  chg2;
    int failCount = 0, nChecks = 0;
    always #5 clock = ~clock;
    port_jkl_override dut (.clock(clock), .sys_rst(sysRst), .ce(1'b1), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat),
        .ack_o(ack), .irq(irq), .pinIn(pinIn), .pinOutVal(outV), .pinDriveEn_n(drvN),
        .pinPullup(pull), .pinInputEn(inEn), .serial3TransmitLine(tx),
        .serial3ClockOut(ck), .serial3ReceiveLine(rx), .serial3ExternalClock(xck),
        .changeSourcesGroupOne(chg1), .changeSourcesGroupTwo(chg2), .timer5CompareEn(cmpEn),
        .timer5CompareOut(cmpOut), .timer5ExternalClock(t5ck),
        .timer5CaptureTrigger(t5cap), .timer4CaptureTrigger(t4cap));
    pad_side_model pads (.clock(clock), .padSet(padSet), .pinIn(pinIn), .txLine(tx),
        .clkOut(ck), .cmpEn(cmpEn), .cmpOut(cmpOut));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // classic cycle held until ack; reads land in rq
    // no local limit: a missing ack is caught by the watchdog
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rq = rdat;
        {cyc, stb, we} <= 3'b000;
        @(negedge clock);
    endtask : bus
    task final_report;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // transmit takes pin j1; compare outputs take pins l5..l3
    task txScene;
        bus(1, CTRL_OFS, 32'h0000_0008);
        chk({drvN[1], pull[1], outV[1]}, {2'b00, ~tx});
        chk(outV[21:19], {3{~tx}});
    endtask : txScene
    // receiver forces j0 in; pull-up follows latch unless disabled globally
    task rxScene;
        bus(1, JLAT_OFS, 32'h0000_0001);
        bus(1, JDIR_OFS, 32'h0000_0001);
        bus(1, CTRL_OFS, 32'h0000_0010);
        chk({drvN[0], pull[0]}, 2'b11);
        bus(1, CTRL_OFS, 32'h0000_0011);
        chk(pull[0], 0);
    endtask : rxScene
    // change event held back by the mask, raised, then cleared by a read
    task changeScene;
        bus(1, MASK1_OFS, 32'h0000_0008);
        bus(1, CTRL_OFS, 32'h0000_0002);
        padSet <= 24'h04_0008;
        repeat (8) @(negedge clock);
        chk(chg1, 7'h08);
        chk(irq, 0);
        chk(t5ck, 1);
        bus(1, IMSK_OFS, 32'h0000_0001);
        chk(irq, 1);
        bus(0, STAT_OFS, 32'h0000_0000);
        chk(rq, 1);
        repeat (2) @(negedge clock);
        chk(irq, 0);
        bus(0, 8'h3C, 32'h0000_0000);
        chk(rq, 0);
    endtask : changeScene
    // port k: a mask bit forces input on over a disabled pin, the rest stay off
    task kScene;
        bus(1, KDIS_OFS, 32'h0000_00FF);
        bus(1, MASK2_OFS, 32'h0000_0001);
        bus(1, CTRL_OFS, 32'h0000_0004);
        chk(inEn[15:8], 8'h01);
        padSet <= 24'h07_FF09;
        repeat (8) @(negedge clock);
        chk(chg2, 8'h01);
        chk({t5ck, t5cap, t4cap, rx}, 4'hF);
        bus(0, STAT_OFS, 32'h0000_0000);
        chk(rq, 2);
    endtask : kScene
    // serial clock on j2: driven in synchronous mode, read back as an input
    task xckScene;
        padSet <= 24'h07_FF0D;
        bus(1, JDIR_OFS, 32'h0000_0004);
        bus(1, CTRL_OFS, 32'h0000_0020);
        chk({drvN[2], outV[2]}, {1'b0, tx});
        chk(xck, 0);
        bus(1, JDIR_OFS, 32'h0000_0000);
        chk({drvN[2], xck}, 2'b11);
        bus(1, CTRL_OFS, 32'h0000_0000);
        chk(xck, 0);
    endtask : xckScene
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {sysRst, cyc, stb, we, adr, sel, dat, padSet} = {4'h8, 8'h00, 4'hF, 56'h0};
        repeat (12) @(posedge clock);
        sysRst <= 1'b0;
        @(negedge clock);
        chk({drvN, inEn}, {2{24'hFF_FFFF}});
        txScene();
        rxScene();
        changeScene();
        kScene();
        xckScene();
        final_report();
    end
    // watchdog well past the roughly 85 cycles the scenes need
    initial begin
        repeat (5000) @(posedge clock);
        failCount++;
        final_report();
    end
endmodule : port_jkl_override_bench
`default_nettype wire
